// ### phy_mdio_mgmt_isolate.sv
// Purpose: Management serial slave with address straps and isolate mode
// Assumes: MDC, MDIO, straps and transmit pins are asynchronous to CLOCK
// Notes: MDC must stay well below CLOCK/4 so each edge is seen
`timescale 1ns/1ps
`default_nettype none
module phy_mdio_mgmt_isolate (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic MDC,
  input wire logic MDIO_IN,
  output logic MDIO_OUT,
  output logic MDIO_OE_N,
  input wire logic STRAP_COL,
  input wire logic [mdio_pkg::TXD_W-1:0] STRAP_RXD,
  input wire logic TX_EN,
  input wire logic [mdio_pkg::TXD_W-1:0] TXD,
  output logic TX_EN_CORE,
  output logic [mdio_pkg::TXD_W-1:0] TXD_CORE,
  output logic MII_OE_N,
  output logic ISOLATE,
  input wire logic [mdio_pkg::REG_AW-1:0] ADDR,
  input wire logic [mdio_pkg::REG_DW-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [mdio_pkg::REG_DW-1:0] RDATA
);
  import mdio_pkg::*;

  typedef struct packed {
    logic [2:0] mdc_s;
    logic [1:0] mdio_s;
    logic [PHY_ADDRESS_STRAP_W-1:0] strap_s1;
    logic [PHY_ADDRESS_STRAP_W-1:0] strap_s2;
    logic [TXD_W:0] tx_s1;
    logic [TXD_W:0] tx_s2;
    logic [1:0] settle;
    logic strapped;
    logic strap_zero;
    mstate_t st;
    logic synced;
    logic [4:0] cnt;
    logic [1:0] op;
    logic [PHY_ADDRESS_STRAP_W-1:0] pa;
    logic [REG_AW-1:0] ra;
    logic [REG_DW-1:0] sh;
    logic match;
    logic [31:0][REG_DW-1:0] regs;
    logic [REG_DW-1:0] rdata;
    logic mdio_out;
    logic mdio_oe_n;
    logic isolate;
    logic mii_oe_n;
    logic tx_en_core;
    logic [TXD_W-1:0] txd_core;
  } state_t;

  state_t q;
  state_t n;

  // Preamble-suppression capability is hardwired, not stored
  function automatic logic [REG_DW-1:0] read_value(input state_t s, input logic [REG_AW-1:0] a);
    logic [REG_DW-1:0] v;
    v = s.regs[a];
    if (a == BASIC_STATUS_ADDR) begin
      v = v | PRESUP_MASK;
    end
    return v;
  endfunction

  logic mdc_rise;
  logic line_bit;
  assign mdc_rise = q.mdc_s[1] & ~q.mdc_s[2];
  assign line_bit = q.mdio_s[1];

  always_comb begin
    logic bad;
    logic [1:0] op_now;
    logic [REG_AW-1:0] ra_now;
    bad = 1'b0;
    op_now = {q.op[0], line_bit};
    ra_now = {q.ra[REG_AW-2:0], line_bit};
    n = q;
    n.mdc_s = {q.mdc_s[1:0], MDC};
    n.mdio_s = {q.mdio_s[0], MDIO_IN};
    n.strap_s1 = {STRAP_RXD, STRAP_COL};
    n.strap_s2 = q.strap_s1;
    n.tx_s1 = {TXD, TX_EN};
    n.tx_s2 = q.tx_s1;
    n.rdata = '0;
    // Wait for the strap synchronisers to fill before latching
    if (!q.strapped) begin
      if (q.settle == STRAP_SETTLE) begin
        n.strapped = 1'b1;
        n.regs[PHY_CONTROL_ADDR][PHY_ADDRESS_STRAP_W-1:0] = q.strap_s2;
        n.strap_zero = (q.strap_s2 == '0);
      end else begin
        n.settle = q.settle + 2'h1;
      end
    end
    // Isolate never gates the serial path, so management keeps answering
    if (mdc_rise) begin
      case (q.st)
        ST_HUNT: begin
          if (line_bit) begin
            if (q.cnt == PREAMBLE_LAST) begin
              n.synced = 1'b1;
              n.st = ST_IDLE;
            end else begin
              n.cnt = q.cnt + 5'h01;
            end
          end else begin
            n.cnt = '0;
          end
        end
        ST_IDLE: begin
          if (!line_bit) begin
            n.st = ST_START;
          end
        end
        ST_START: begin
          if (line_bit) begin
            n.st = ST_OP;
            n.cnt = '0;
          end else begin
            bad = 1'b1;
          end
        end
        ST_OP: begin
          n.op = op_now;
          if (q.cnt == OP_LAST) begin
            if (op_now == OP_READ || op_now == OP_WRITE) begin
              n.st = ST_PHY;
              n.cnt = '0;
            end else begin
              bad = 1'b1;
            end
          end else begin
            n.cnt = q.cnt + 5'h01;
          end
        end
        ST_PHY: begin
          n.pa = {q.pa[PHY_ADDRESS_STRAP_W-2:0], line_bit};
          n.cnt = q.cnt + 5'h01;
          if (q.cnt == ADDR_LAST) begin
            n.st = ST_REG;
            n.cnt = '0;
          end
        end
        ST_REG: begin
          n.ra = ra_now;
          n.cnt = q.cnt + 5'h01;
          if (q.cnt == ADDR_LAST) begin
            n.st = ST_TA;
            n.cnt = '0;
            n.match = (q.pa == q.regs[PHY_CONTROL_ADDR][PHY_ADDRESS_STRAP_W-1:0]);
            n.sh = read_value(q, ra_now);
          end
        end
        ST_TA: begin
          if (q.cnt != TA_SECOND) begin
            n.cnt = TA_SECOND;
            if (q.op == OP_WRITE && !line_bit) begin
              bad = 1'b1;
            end else if (q.op == OP_READ && q.match) begin
              n.mdio_oe_n = 1'b0;
              n.mdio_out = 1'b0;
            end
          end else begin
            if (q.op == OP_WRITE && line_bit) begin
              bad = 1'b1;
            end else begin
              n.st = ST_DATA;
              n.cnt = '0;
              // Released line stays low so no stale data bit is shown
              n.mdio_out = q.sh[REG_DW-1] & ~q.mdio_oe_n;
            end
          end
        end
        ST_DATA: begin
          n.cnt = q.cnt + 5'h01;
          if (q.op == OP_READ) begin
            n.sh = {q.sh[REG_DW-2:0], 1'b0};
            n.mdio_out = q.sh[REG_DW-2] & ~q.mdio_oe_n;
          end else begin
            n.sh = {q.sh[REG_DW-2:0], line_bit};
          end
          if (q.cnt == DATA_LAST) begin
            n.st = ST_IDLE;
            n.mdio_oe_n = 1'b1;
            n.mdio_out = 1'b0;
            if (q.op == OP_WRITE && q.match) begin
              n.regs[q.ra] = {q.sh[REG_DW-2:0], line_bit};
            end
          end
        end
        default: begin
          bad = 1'b1;
        end
      endcase
    end
    if (bad) begin
      n.st = ST_HUNT;
      n.synced = 1'b0;
      n.cnt = '0;
      n.mdio_oe_n = 1'b1;
      n.mdio_out = 1'b0;
    end
    // Local bus write lands after a same-cycle serial write
    if (WR) begin
      n.regs[ADDR] = WDATA;
    end
    if (RD) begin
      n.rdata = read_value(q, ADDR);
    end
    // The strap flag or control bit ten isolates; a written zero address does not
    n.isolate = n.strap_zero | n.regs[BASIC_CONTROL_ADDR][ISOLATE_BIT];
    n.mii_oe_n = n.isolate;
    n.tx_en_core = n.isolate ? 1'b0 : q.tx_s2[0];
    n.txd_core = n.isolate ? '0 : q.tx_s2[TXD_W:1];
    if (RST) begin
      n = '0;
      n.regs[PHY_CONTROL_ADDR][PHY_ADDRESS_STRAP_W-1:0] = PHY_ADDRESS_STRAP_DEFAULT;
      n.mdio_oe_n = 1'b1;
    end
  end

  always_ff @(posedge CLOCK) begin
    q <= n;
  end

  assign MDIO_OUT = q.mdio_out;
  assign MDIO_OE_N = q.mdio_oe_n;
  assign TX_EN_CORE = q.tx_en_core;
  assign TXD_CORE = q.txd_core;
  assign MII_OE_N = q.mii_oe_n;
  assign ISOLATE = q.isolate;
  assign RDATA = q.rdata;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  sequence read_ta_first;
    mdc_rise && q.st == ST_TA && q.cnt != TA_SECOND && q.op == OP_READ && q.match;
  endsequence

  sequence strap_latch;
    !q.strapped ##1 q.strapped;
  endsequence

  chk_unsync_quiet: assert property (!q.synced |-> MDIO_OE_N)
    else $error("slave drives the line before preamble");
  chk_ta_release: assert property (q.st == ST_TA && q.cnt != TA_SECOND |-> MDIO_OE_N)
    else $error("line driven in first turnaround bit");
  chk_ta_zero_data: assert property (read_ta_first |=> !MDIO_OE_N && !MDIO_OUT
    ##0 (q.st == ST_TA)[*1] )
    else $error("second turnaround bit not driven low");
  chk_status_presup: assert property (RD && ADDR == BASIC_STATUS_ADDR |=> RDATA[PRESUP_BIT])
    else $error("preamble suppression bit reads zero");
  chk_basic_control_reg_isolate: assert property (WR && ADDR == BASIC_CONTROL_ADDR && WDATA[ISOLATE_BIT]
    |=> ISOLATE && MII_OE_N && !TX_EN_CORE)
    else $error("control bit ten did not isolate");
  chk_written_zero: assert property (WR && ADDR == PHY_CONTROL_ADDR && WDATA[PHY_ADDRESS_STRAP_W-1:0] == '0
    && !q.strap_zero && !q.regs[BASIC_CONTROL_ADDR][ISOLATE_BIT] |=> !ISOLATE)
    else $error("written zero address isolated the device");
  chk_isolate_tx: assert property (ISOLATE |-> !TX_EN_CORE && TXD_CORE == '0 && MII_OE_N)
    else $error("transmit inputs pass while isolated");
  chk_bad_start: assert property (mdc_rise && q.st == ST_START && !line_bit |=> !q.synced
    && q.st == ST_HUNT)
    else $error("invalid start did not drop synchronisation");
  chk_strap_latch: assert property (strap_latch |-> $past(WR && ADDR == PHY_CONTROL_ADDR) ||
    q.regs[PHY_CONTROL_ADDR][PHY_ADDRESS_STRAP_W-1:0] == $past(q.strap_s2))
    else $error("strap address not latched");
  chk_mismatch_quiet: assert property (q.st == ST_DATA && !q.match |-> MDIO_OE_N)
    else $error("slave answered a foreign address");
  chk_release_low: assert property (MDIO_OE_N |-> !MDIO_OUT)
    else $error("data output not low while line released");
endmodule
`default_nettype wire

// ### mdio_pkg.sv
// Purpose: Shared constants and types for the management serial slave
// Assumes: Register index is the five-bit management register address
// Notes: Frame field widths follow the serial management frame layout
package mdio_pkg;
  localparam int REG_AW = 5;
  localparam int REG_DW = 16;
  localparam int PHY_ADDRESS_STRAP_W = 5;
  localparam int TXD_W = 4;

  localparam logic [REG_AW-1:0] BASIC_CONTROL_ADDR = 5'h00;
  localparam logic [REG_AW-1:0] BASIC_STATUS_ADDR = 5'h01;
  localparam logic [REG_AW-1:0] PHY_CONTROL_ADDR = 5'h19;
  localparam int ISOLATE_BIT = 10;
  localparam int PRESUP_BIT = 6;
  localparam logic [REG_DW-1:0] PRESUP_MASK = 16'h0040;
  localparam logic [PHY_ADDRESS_STRAP_W-1:0] PHY_ADDRESS_STRAP_DEFAULT = 5'h01;

  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [4:0] PREAMBLE_LAST = 5'h1f;
  localparam logic [4:0] OP_LAST = 5'h01;
  localparam logic [4:0] ADDR_LAST = 5'h04;
  localparam logic [4:0] TA_SECOND = 5'h01;
  localparam logic [4:0] DATA_LAST = 5'h0f;
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  typedef enum logic [2:0] {
    ST_HUNT,
    ST_IDLE,
    ST_START,
    ST_OP,
    ST_PHY,
    ST_REG,
    ST_TA,
    ST_DATA
  } mstate_t;
endpackage

// ### mdio_station.sv
// Purpose: Station model that clocks frames onto the management line
// Assumes: Line is pulled up by the bench whenever nobody drives it
// Notes: Clock rests low between frames, one bit is eight CLOCK cycles
`timescale 1ns/1ps
`default_nettype none
module mdio_station (
  input wire logic clk,
  input wire logic line,
  output logic mdc,
  output logic drv,
  output logic drv_oe_n
);
  initial begin
    mdc = 1'b0;
    drv = 1'b1;
    drv_oe_n = 1'b1;
  end
  // Data set while low, line sampled at the rise; 800 ns bit time
  task automatic bit_time(input logic b, input logic en, output logic s);
    drv <= b;
    drv_oe_n <= !en;
    repeat (4) @(posedge clk);
    s = line;
    mdc <= 1'b1;
    repeat (4) @(posedge clk);
    mdc <= 1'b0;
  endtask
  task automatic frame(input int pre, input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [1:0] ta, input logic [15:0] wd, output logic [17:0] rd);
    logic [13:0] hdr;
    logic [17:0] v;
    logic s;
    logic w;
    hdr = {2'b01, op, pa, ra};
    v = {ta, wd};
    w = (op == 2'b01);
    @(posedge clk);
    for (int i = 0; i < pre; i++) bit_time(1'b1, 1'b1, s);
    bit_time(1'b1, 1'b0, s);
    for (int i = 13; i >= 0; i--) bit_time(hdr[i], 1'b1, s);
    // Reads release the line from the first turnaround bit on
    for (int i = 17; i >= 0; i--) begin
      bit_time(v[i], w, s);
      rd[i] = s;
    end
    drv_oe_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ### testbench.sv
// Purpose: Self-checking bench for the management serial slave
// Assumes: One station on the line, pull-up when the line is released
// Notes: Reset case first, then frame table, resync, isolate and strap cases
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mdio_pkg::*;
  typedef struct {int pre; logic [1:0] op; logic [4:0] pa; logic [4:0] ra; logic [15:0] d; logic [17:0] e;} row_t;
  localparam logic [17:0] NONE = 18'h3ffff;
  logic CLOCK = 1'b0, RST = 1'b1, STRAP_COL = 1'b1, TX_EN = 1'b0, WR = 1'b0, RD = 1'b0;
  logic [3:0] STRAP_RXD = 4'h0, TXD = 4'h0, TXD_CORE;
  logic [4:0] ADDR = 5'h00;
  logic [15:0] WDATA = 16'h0000, RDATA, word;
  logic MDIO_IN, MDIO_OUT, MDIO_OE_N, TX_EN_CORE, MII_OE_N, ISOLATE, mdc, sta_drv, sta_oe_n, sbit;
  logic [17:0] got;
  int n_errors = 0, num_checks = 0;
  row_t rows [8] = '{
    '{32, OP_WRITE, 5'h01, 5'h02, 16'h1234, 18'h0},
    '{0, OP_READ, 5'h01, 5'h02, 16'h0, 18'h21234},
    '{0, OP_READ, 5'h01, BASIC_STATUS_ADDR, 16'h0, 18'h20040},
    '{0, OP_WRITE, 5'h02, 5'h03, 16'h5678, 18'h0},
    '{0, OP_READ, 5'h01, 5'h03, 16'h0, 18'h20000},
    '{0, OP_READ, 5'h02, 5'h02, 16'h0, NONE},
    '{0, OP_WRITE, 5'h01, 5'h1f, 16'hffff, 18'h0},
    '{0, OP_READ, 5'h01, 5'h1f, 16'h0, 18'h2ffff}};
  always #50 CLOCK = ~CLOCK;
  // Pull-up wins only when both sides have let go
  assign MDIO_IN = !MDIO_OE_N ? MDIO_OUT : (!sta_oe_n ? sta_drv : 1'b1);
  phy_mdio_mgmt_isolate dut (.CLOCK(CLOCK), .RST(RST), .MDC(mdc), .MDIO_IN(MDIO_IN), .MDIO_OUT(MDIO_OUT),
    .MDIO_OE_N(MDIO_OE_N), .STRAP_COL(STRAP_COL), .STRAP_RXD(STRAP_RXD), .TX_EN(TX_EN), .TXD(TXD),
    .TX_EN_CORE(TX_EN_CORE), .TXD_CORE(TXD_CORE), .MII_OE_N(MII_OE_N), .ISOLATE(ISOLATE), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA));
  mdio_station sta (.clk(CLOCK), .line(MDIO_IN), .mdc(mdc), .drv(sta_drv), .drv_oe_n(sta_oe_n));
  task automatic check(input logic [17:0] g, input logic [17:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic do_reset;
    RST <= 1'b1;
    repeat (12) @(posedge CLOCK);
    RST <= 1'b0;
    repeat (5) @(posedge CLOCK);
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge CLOCK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLOCK);
    WR <= 1'b0;
  endtask
  task automatic rdl(input logic [4:0] a, output logic [15:0] d);
    @(posedge CLOCK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLOCK);
    RD <= 1'b0;
    @(posedge CLOCK);
    d = RDATA;
  endtask
  task automatic rd_mdio(input int pre, input logic [4:0] pa, input logic [4:0] ra);
    sta.frame(pre, OP_READ, pa, ra, 2'b10, 16'h0, got);
  endtask
  initial begin
    repeat (100000) @(posedge CLOCK);
    n_errors++;
    complete_run();
  end
  initial begin
    do_reset();
    rdl(PHY_CONTROL_ADDR, word);
    check({2'b0, word}, {13'h0, PHY_ADDRESS_STRAP_DEFAULT});
    #1 check({2'b0, RDATA}, 18'h0);
    // Thirty ones plus the idle bit stay one short of a full preamble
    rd_mdio(30, 5'h01, BASIC_STATUS_ADDR);
    check(got, NONE);
    $display("test reset done");
    foreach (rows[i]) begin
      sta.frame(rows[i].pre, rows[i].op, rows[i].pa, rows[i].ra, 2'b10, rows[i].d, got);
      if (rows[i].op == OP_READ) check(got, rows[i].e);
    end
    $display("test frame table done");
    sta.frame(0, 2'b11, 5'h01, 5'h02, 2'b10, 16'h0, got);
    rd_mdio(0, 5'h01, 5'h02);
    check(got, NONE);
    sta.frame(32, OP_WRITE, 5'h01, 5'h02, 2'b11, 16'h9999, got);
    rd_mdio(0, 5'h01, 5'h02);
    check(got, NONE);
    rd_mdio(32, 5'h01, 5'h02);
    check(got, 18'h21234);
    @(posedge CLOCK);
    sta.bit_time(1'b0, 1'b1, sbit);
    sta.bit_time(1'b0, 1'b1, sbit);
    rd_mdio(0, 5'h01, 5'h02);
    check(got, NONE);
    $display("test resync done");
    wr(5'h04, 16'hbeef);
    rd_mdio(32, 5'h01, 5'h04);
    check(got, 18'h2beef);
    wr(BASIC_STATUS_ADDR, 16'h8001);
    rdl(BASIC_STATUS_ADDR, word);
    check({2'b0, word}, 18'h08041);
    TX_EN <= 1'b1;
    TXD <= 4'ha;
    wr(PHY_CONTROL_ADDR, 16'h0000);
    repeat (4) @(posedge CLOCK);
    check({11'h0, TX_EN_CORE, TXD_CORE, MII_OE_N, ISOLATE}, 18'h00068);
    wr(BASIC_CONTROL_ADDR, 16'h0400);
    repeat (4) @(posedge CLOCK);
    check({11'h0, TX_EN_CORE, TXD_CORE, MII_OE_N, ISOLATE}, 18'h00003);
    rd_mdio(0, 5'h00, BASIC_CONTROL_ADDR);
    check(got, 18'h20400);
    $display("test isolate control done");
    // Asymmetric pattern so a reversed strap order shows up
    STRAP_RXD <= 4'h3;
    do_reset();
    rdl(PHY_CONTROL_ADDR, word);
    check({1'b0, word, ISOLATE}, 18'h0000e);
    STRAP_COL <= 1'b0;
    STRAP_RXD <= 4'h0;
    do_reset();
    check({11'h0, TX_EN_CORE, TXD_CORE, MII_OE_N, ISOLATE}, 18'h00003);
    rd_mdio(32, 5'h00, BASIC_STATUS_ADDR);
    check(got, 18'h20040);
    $display("test straps done");
    complete_run();
  end
endmodule
`default_nettype wire
